// file: hdl/gpb_pkg.sv
// Constants, register map and carrier types of the general-purpose port block.
// Assumes a 32-bit APB slave with word-aligned registers and one 40 MHz clock.
//
// Functional notes
// - Fifteen pins form three ports: two bidirectional ports and one input-only port.
// - Bidirectional pins serve as general-purpose I/O or as peripheral alternate I/O.
// - A per-port direction register enables either the output or the input driver, never both; both stay on for one clock after a switch to input.
// - After reset every bidirectional pin is an input with its output driver off.
// - In input mode the pin level passes a Schmitt trigger and reads back as a pin value.
// - In output mode the driver is on and drives whatever the output multiplexer selects; in open-drain style a selected high turns the driver off.
// - A per-port register switches each output between open-drain and push-pull.
// - For general-purpose output the pin value register bit drives the pin directly.
// - Two per-port alternate-select registers route a peripheral output line to the driver.
// - Every pin has a weak pull whose polarity and enable are per-port registers.
// - The third port is input only; its direction register only gates the input driver.
// - On the input-only port the analog path bypasses the digital input and Schmitt trigger.
package gpb_pkg;
	localparam int GPB_PORT_ZERO_PINS = 5;
	localparam int GPB_PORT_ONE_PINS = 5;
	localparam int GPB_PORT_TWO_PINS = 5;
	localparam int GPB_MAX_PINS = 8;
	localparam int GPB_SYNC_STAGES = 2;

	// Register byte offsets, one word apiece
	localparam logic [7:0] GPB_OFS_VALUE = 8'h00;
	localparam logic [7:0] GPB_OFS_WAY = 8'h04;
	localparam logic [7:0] GPB_OFS_DRAIN = 8'h08;
	localparam logic [7:0] GPB_OFS_ALT_LOW = 8'h0C;
	localparam logic [7:0] GPB_OFS_ALT_HIGH = 8'h10;
	localparam logic [7:0] GPB_OFS_PULL_POL = 8'h14;
	localparam logic [7:0] GPB_OFS_PULL_ON = 8'h18;
	localparam logic [7:0] GPB_PORT_STRIDE = 8'h20;
	localparam logic [1:0] GPB_PORT_ZERO_SEL = 2'h0;
	localparam logic [1:0] GPB_PORT_ONE_SEL = 2'h1;
	localparam logic [1:0] GPB_PORT_TWO_SEL = 2'h2;

	// Reset values: inputs, push-pull, general output, pulls off
	localparam logic [7:0] GPB_RST_VALUE = 8'h00;
	localparam logic [7:0] GPB_RST_WAY = 8'h00;
	localparam logic [7:0] GPB_RST_DRAIN = 8'h00;
	localparam logic [7:0] GPB_RST_ALT = 8'h00;
	localparam logic [7:0] GPB_RST_PULL_POL = 8'h00;
	localparam logic [7:0] GPB_RST_PULL_ON = 8'h00;

	// Output source codes
	typedef enum logic [1:0] {
		GPB_SRC_GENERAL = 2'h0,
		GPB_SRC_ALT_ONE = 2'h1,
		GPB_SRC_ALT_TWO = 2'h2,
		GPB_SRC_ALT_THREE = 2'h3
	} gpb_src_t;

	// Control bits of one bidirectional port
	typedef struct packed {
		logic [GPB_MAX_PINS-1:0] pin_value_reg;
		logic [GPB_MAX_PINS-1:0] pin_way_select;
		logic [GPB_MAX_PINS-1:0] drain_style_select;
		logic [GPB_MAX_PINS-1:0] alt_source_low;
		logic [GPB_MAX_PINS-1:0] alt_source_high;
		logic [GPB_MAX_PINS-1:0] pull_polarity_select;
		logic [GPB_MAX_PINS-1:0] pull_switch_on;
	} gpb_port_cfg_t;

	// APB request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} gpb_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} gpb_apb_rsp_t;
endpackage

// file: hdl/gpb_sync.sv
// Two-stage level synchroniser acting as the digital Schmitt stage of one port.
// Assumes pin levels are already clean digital values from the pad.
`timescale 1ns/100ps
module gpb_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [WIDTH-1:0] level_in, // Raw pad levels
	output logic [WIDTH-1:0] level_out // Settled levels
);
	import gpb_pkg::*;

	logic [WIDTH-1:0] first_stage;

	// First flop feeds only the second one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			first_stage <= '0;
			level_out <= '0;
		end else begin
			first_stage <= level_in;
			level_out <= first_stage;
		end
	end
endmodule

// file: hdl/gpb_port.sv
// One bidirectional port: control registers, output multiplexer and pin drive.
// Assumes the APB slave in the top presents one-cycle write strobes per register.
`timescale 1ns/100ps
module gpb_port #(
	parameter int PINS = 5
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [6:0] wr_strobe, // One-hot register write, offset order
	input wire logic [PINS-1:0] wr_data, // Write data
	input wire logic [PINS-1:0] pin_in, // Pad levels
	input wire logic [PINS-1:0] alt_one, // Peripheral output line, source one
	input wire logic [PINS-1:0] alt_two, // Peripheral output line, source two
	input wire logic [PINS-1:0] alt_three, // Peripheral output line, source three
	output gpb_pkg::gpb_port_cfg_t cfg, // Register contents
	output logic [PINS-1:0] pin_level, // Settled input levels
	output logic [PINS-1:0] pin_out, // Pad output value
	output logic [PINS-1:0] pin_oe, // Pad output enable
	output logic [PINS-1:0] pull_up_on, // Weak pull-up active
	output logic [PINS-1:0] pull_down_on // Weak pull-down active
);
	import gpb_pkg::*;

	logic [PINS-1:0] settled;
	logic [PINS-1:0] next_drive;
	logic [PINS-1:0] next_oe;

	gpb_sync #(.WIDTH(PINS)) u_sync (
		.clock(clock),
		.rst(rst),
		.level_in(pin_in),
		.level_out(settled)
	);

	// Control registers, bit n belongs to pin n
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg.pin_value_reg <= GPB_RST_VALUE;
			cfg.pin_way_select <= GPB_RST_WAY;
			cfg.drain_style_select <= GPB_RST_DRAIN;
			cfg.alt_source_low <= GPB_RST_ALT;
			cfg.alt_source_high <= GPB_RST_ALT;
			cfg.pull_polarity_select <= GPB_RST_PULL_POL;
			cfg.pull_switch_on <= GPB_RST_PULL_ON;
		end else begin
			if (wr_strobe[0]) cfg.pin_value_reg <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[1]) cfg.pin_way_select <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[2]) cfg.drain_style_select <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[3]) cfg.alt_source_low <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[4]) cfg.alt_source_high <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[5]) cfg.pull_polarity_select <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
			if (wr_strobe[6]) cfg.pull_switch_on <= {{(GPB_MAX_PINS-PINS){1'b0}}, wr_data};
		end
	end

	// Input path is gated off while the direction bit selects output
	assign pin_level = settled & ~cfg.pin_way_select[PINS-1:0];

	// Output multiplexer and driver
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			unique case (gpb_src_t'({cfg.alt_source_high[i], cfg.alt_source_low[i]}))
				GPB_SRC_GENERAL: next_drive[i] = cfg.pin_value_reg[i];
				GPB_SRC_ALT_ONE: next_drive[i] = alt_one[i];
				GPB_SRC_ALT_TWO: next_drive[i] = alt_two[i];
				GPB_SRC_ALT_THREE: next_drive[i] = alt_three[i];
			endcase
			// Open drain only ever pulls low; a high releases the pad
			next_oe[i] = cfg.pin_way_select[i] & ~(cfg.drain_style_select[i] & next_drive[i]);
		end
	end

	// Registered drive so pads never see mux glitches
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			pin_out <= next_drive;
			pin_oe <= next_oe;
		end
	end

	assign pull_up_on = cfg.pull_switch_on[PINS-1:0] & cfg.pull_polarity_select[PINS-1:0];
	assign pull_down_on = cfg.pull_switch_on[PINS-1:0] & ~cfg.pull_polarity_select[PINS-1:0];
endmodule

// file: hdl/gpb_top.sv
// Three-port pin block with APB register access.
// Assumes an APB master on the system clock; pads resolve level from out and enable.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module gpb_top (
	input wire logic clock, // System clock, 40 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [4:0] port_zero_in, // Port zero pad levels
	output logic [4:0] port_zero_out, // Port zero pad value
	output logic [4:0] port_zero_oe, // Port zero pad enable
	output logic [4:0] port_zero_pull_up, // Port zero pull-up on
	output logic [4:0] port_zero_pull_down, // Port zero pull-down on
	input wire logic [14:0] port_zero_alt, // Port zero peripheral output lines
	input wire logic [4:0] port_one_in, // Port one pad levels
	output logic [4:0] port_one_out, // Port one pad value
	output logic [4:0] port_one_oe, // Port one pad enable
	output logic [4:0] port_one_pull_up, // Port one pull-up on
	output logic [4:0] port_one_pull_down, // Port one pull-down on
	input wire logic [14:0] port_one_alt, // Port one peripheral output lines
	output logic [4:0] port_zero_level, // Port zero levels to peripherals
	output logic [4:0] port_one_level, // Port one levels to peripherals
	input wire logic [4:0] port_two_in, // Port two digital pad levels
	input wire logic [4:0] port_two_analog, // Port two analog pad taps
	output logic [4:0] converter_feed_line, // Analog feed to converter channels
	output logic [4:0] port_two_level, // Port two levels to peripherals
	output logic [4:0] port_two_pull_up, // Port two pull-up on
	output logic [4:0] port_two_pull_down // Port two pull-down on
);
	import gpb_pkg::*;

	gpb_port_cfg_t cfg_zero;
	gpb_port_cfg_t cfg_one;
	logic [6:0] strobe_zero;
	logic [6:0] strobe_one;
	logic [4:0] input_port_driver_on;
	logic [4:0] input_port_pull_polarity;
	logic [4:0] input_port_pull_on;
	logic [4:0] two_settled;
	logic [4:0] input_port_value;
	logic [1:0] port_sel;
	logic [7:0] reg_ofs;
	logic hit;
	logic wr_go;
	logic rd_go;
	logic [31:0] next_rdata;
	gpb_port_cfg_t sel_cfg;
	logic [4:0] sel_lvl;

	// Register view of whichever bidirectional port the address picks
	assign sel_cfg = (port_sel == GPB_PORT_ZERO_SEL) ? cfg_zero : cfg_one;
	assign sel_lvl = (port_sel == GPB_PORT_ZERO_SEL) ? port_zero_level : port_one_level;

	// Address split: port in bits 6:5, register in bits 4:0
	assign port_sel = paddr[6:5];
	assign reg_ofs = {3'h0, paddr[4:0]};
	assign wr_go = psel & penable & pwrite & ~pslverr;
	assign rd_go = psel & ~penable & ~pwrite;

	// Decode; port two has value, way and pull registers only
	always_comb begin
		hit = 1'b0;
		if (paddr[7] == 1'b0 && paddr[1:0] == 2'h0) begin
			if (port_sel == GPB_PORT_ZERO_SEL || port_sel == GPB_PORT_ONE_SEL) begin
				hit = reg_ofs <= GPB_OFS_PULL_ON;
			end else if (port_sel == GPB_PORT_TWO_SEL) begin
				hit = reg_ofs == GPB_OFS_VALUE || reg_ofs == GPB_OFS_WAY
					|| reg_ofs == GPB_OFS_PULL_POL || reg_ofs == GPB_OFS_PULL_ON;
			end
		end
	end

	// Zero-wait slave; errors flag unmapped words in the access phase
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Write strobes per port, one per register word
	always_comb begin
		strobe_zero = '0;
		strobe_one = '0;
		if (wr_go && port_sel == GPB_PORT_ZERO_SEL) strobe_zero[reg_ofs[4:2]] = 1'b1;
		if (wr_go && port_sel == GPB_PORT_ONE_SEL) strobe_one[reg_ofs[4:2]] = 1'b1;
	end

	gpb_port #(.PINS(GPB_PORT_ZERO_PINS)) u_port_zero (
		.clock(clock),
		.rst(rst),
		.wr_strobe(strobe_zero),
		.wr_data(pwdata[4:0]),
		.pin_in(port_zero_in),
		.alt_one(port_zero_alt[4:0]),
		.alt_two(port_zero_alt[9:5]),
		.alt_three(port_zero_alt[14:10]),
		.cfg(cfg_zero),
		.pin_level(port_zero_level),
		.pin_out(port_zero_out),
		.pin_oe(port_zero_oe),
		.pull_up_on(port_zero_pull_up),
		.pull_down_on(port_zero_pull_down)
	);

	gpb_port #(.PINS(GPB_PORT_ONE_PINS)) u_port_one (
		.clock(clock),
		.rst(rst),
		.wr_strobe(strobe_one),
		.wr_data(pwdata[4:0]),
		.pin_in(port_one_in),
		.alt_one(port_one_alt[4:0]),
		.alt_two(port_one_alt[9:5]),
		.alt_three(port_one_alt[14:10]),
		.cfg(cfg_one),
		.pin_level(port_one_level),
		.pin_out(port_one_out),
		.pin_oe(port_one_oe),
		.pull_up_on(port_one_pull_up),
		.pull_down_on(port_one_pull_down)
	);

	// Input-only port: Schmitt stage for the digital path
	gpb_sync #(.WIDTH(GPB_PORT_TWO_PINS)) u_sync_two (
		.clock(clock),
		.rst(rst),
		.level_in(port_two_in),
		.level_out(two_settled)
	);

	// Analog taps skip the digital path entirely
	assign converter_feed_line = port_two_analog;

	// Input-only port registers; no output driver exists to control
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			input_port_driver_on <= GPB_RST_WAY[4:0];
			input_port_pull_polarity <= GPB_RST_PULL_POL[4:0];
			input_port_pull_on <= GPB_RST_PULL_ON[4:0];
		end else if (wr_go && port_sel == GPB_PORT_TWO_SEL) begin
			if (reg_ofs == GPB_OFS_WAY) input_port_driver_on <= pwdata[4:0];
			if (reg_ofs == GPB_OFS_PULL_POL) input_port_pull_polarity <= pwdata[4:0];
			if (reg_ofs == GPB_OFS_PULL_ON) input_port_pull_on <= pwdata[4:0];
		end
	end

	// Disabled input driver reads as zero
	assign input_port_value = two_settled & input_port_driver_on;
	assign port_two_level = input_port_value;
	assign port_two_pull_up = input_port_pull_on & input_port_pull_polarity;
	assign port_two_pull_down = input_port_pull_on & ~input_port_pull_polarity;

	// Read mux; value word shows pad level on inputs and latch on outputs
	always_comb begin
		next_rdata = '0;
		if (port_sel == GPB_PORT_TWO_SEL) begin
			unique case (reg_ofs)
				GPB_OFS_VALUE: next_rdata[4:0] = input_port_value;
				GPB_OFS_WAY: next_rdata[4:0] = input_port_driver_on;
				GPB_OFS_PULL_POL: next_rdata[4:0] = input_port_pull_polarity;
				GPB_OFS_PULL_ON: next_rdata[4:0] = input_port_pull_on;
				default: next_rdata = '0;
			endcase
		end else if (port_sel == GPB_PORT_ZERO_SEL || port_sel == GPB_PORT_ONE_SEL) begin
			unique case (reg_ofs)
				GPB_OFS_VALUE: next_rdata[4:0] = (sel_cfg.pin_value_reg[4:0]
					& sel_cfg.pin_way_select[4:0]) | sel_lvl;
				GPB_OFS_WAY: next_rdata[7:0] = sel_cfg.pin_way_select;
				GPB_OFS_DRAIN: next_rdata[7:0] = sel_cfg.drain_style_select;
				GPB_OFS_ALT_LOW: next_rdata[7:0] = sel_cfg.alt_source_low;
				GPB_OFS_ALT_HIGH: next_rdata[7:0] = sel_cfg.alt_source_high;
				GPB_OFS_PULL_POL: next_rdata[7:0] = sel_cfg.pull_polarity_select;
				GPB_OFS_PULL_ON: next_rdata[7:0] = sel_cfg.pull_switch_on;
				default: next_rdata = '0;
			endcase
		end
	end

	// Read data captured in setup, stable through the access phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (rd_go) begin
			prdata <= next_rdata;
		end
	end
endmodule

// file: verif/gpb_chk.sv
// Port zero pin checks against a shadow of its register writes.
// Sees top ports only; the shadow assumes zero-wait APB writes.
`timescale 1ns/100ps
module gpb_chk (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [4:0] port_zero_out, // Pad value
	input wire logic [4:0] port_zero_oe, // Pad enable
	input wire logic [4:0] port_zero_pull_up, // Pull-up
	input wire logic [4:0] port_zero_pull_down, // Pull-down
	input wire logic [14:0] port_zero_alt, // Alternate lines
	input wire logic [4:0] port_zero_level, // Level
	input wire logic [4:0] port_two_analog, // Analog tap
	input wire logic [4:0] converter_feed_line // Analog feed
);
	import gpb_pkg::*;
	logic [4:0] sh [7];
	logic [4:0] mux, mux_d, oe_d;
	logic wr;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	assign wr = psel && penable && pwrite && pready && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
	// Shadow of port zero registers by word index
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 7; i++) begin
				sh[i] <= 5'h00;
			end
		end else if (wr && paddr[4:2] != 3'h7) begin
			sh[paddr[4:2]] <= pwdata[4:0];
		end
	end
	// Source picked by the two select bits
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			case ({sh[4][i], sh[3][i]})
				2'h0: mux[i] = sh[0][i];
				2'h1: mux[i] = port_zero_alt[i];
				2'h2: mux[i] = port_zero_alt[i+5];
				default: mux[i] = port_zero_alt[i+10];
			endcase
		end
	end
	// Pad drive lands one edge after its cause
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mux_d <= 5'h00;
			oe_d <= 5'h00;
		end else begin
			mux_d <= mux;
			oe_d <= sh[1] & ~(sh[2] & mux);
		end
	end
	oe_from_way_a: assert property (port_zero_oe == oe_d)
		else $error("pad enable differs from direction and drain style");
	out_from_mux_a: assert property ((port_zero_out & oe_d) == (mux_d & oe_d))
		else $error("pad value differs from selected source");
	pull_up_a: assert property (port_zero_pull_up == (sh[5] & sh[6]))
		else $error("pull-up differs from its registers");
	pull_down_a: assert property (port_zero_pull_down == (~sh[5] & sh[6]))
		else $error("pull-down differs from its registers");
	level_mask_a: assert property ((sh[1] & oe_d & port_zero_level) == 5'h00)
		else $error("output pin shows an input level");
	analog_feed_a: assert property (converter_feed_line == port_two_analog)
		else $error("analog feed not passed straight through");
	reset_input_a: assert property ($fell(rst) |-> port_zero_oe == 5'h00)
		else $error("pad driven right after reset");
	port_three_a: assert property (psel && penable && paddr[7:5] == 3'h3 |-> pslverr)
		else $error("fourth port accepted");
endmodule
bind gpb_top gpb_chk i_gpb_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .port_zero_out, .port_zero_oe, .port_zero_pull_up, .port_zero_pull_down,
	.port_zero_alt, .port_zero_level, .port_two_analog, .converter_feed_line);

// file: verif/gpb_pad_model.sv
// Board side of one five-pin port: level from drive, pull or float.
// Assumes an unpulled released pad wanders; here it toggles each clock.
`timescale 1ns/100ps
module gpb_pad_model (
	input wire logic clock, // Float pattern clock
	input wire logic [4:0] out, // Pad value
	input wire logic [4:0] oe, // Pad enable
	input wire logic [4:0] pu, // Pull-up on
	input wire logic [4:0] pd, // Pull-down on
	output logic [4:0] pad // Resolved level
);
	logic [4:0] drift = 5'h15;
	// Changing float so a stale level never reads back
	always @(posedge clock) begin
		drift <= ~drift;
	end
	// Drive wins, then the weak pull, then the float
	assign pad = (oe & out) | (~oe & pu) | (~oe & ~pu & ~pd & drift);
endmodule

// file: verif/tb_gpb_top.sv
// Bench for the three-port pin block: APB driver, pad models, queued checks.
// Assumes zero-wait APB and two-edge input synchronisers.
`timescale 1ns/100ps
module tb_gpb_top;
	import gpb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [14:0] alt0 = 15'h0, alt1 = 15'h0;
	logic [4:0] ana = 5'h00;
	logic [4:0] o0, e0, u0, d0, l0, o1, e1, u1, d1, l1, f2, l2, u2, d2, pz, po, pt;
	logic [32:0] rq[$];
	logic [4:0] pq[$];
	logic [7:0] r = 8'h5A;
	int probe_k = 0, probe_n = 0, seen_n = 0, fails = 0, compares = 0;
	gpb_top i_gpb_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .port_zero_in(pz), .port_zero_out(o0), .port_zero_oe(e0),
		.port_zero_pull_up(u0), .port_zero_pull_down(d0), .port_zero_alt(alt0),
		.port_one_in(po), .port_one_out(o1), .port_one_oe(e1), .port_one_pull_up(u1),
		.port_one_pull_down(d1), .port_one_alt(alt1), .port_zero_level(l0),
		.port_one_level(l1), .port_two_in(pt), .port_two_analog(ana), .converter_feed_line(f2),
		.port_two_level(l2), .port_two_pull_up(u2), .port_two_pull_down(d2));
	gpb_pad_model i_gpb_pad_model_z (.clock, .out(o0), .oe(e0), .pu(u0), .pd(d0), .pad(pz));
	gpb_pad_model i_gpb_pad_model_o (.clock, .out(o1), .oe(e1), .pu(u1), .pd(d1), .pad(po));
	gpb_pad_model i_gpb_pad_model_t (.clock, .out(5'h00), .oe(5'h00), .pu(u2), .pd(d2), .pad(pt));
	initial begin
		forever #12.5 clock = ~clock;
	end
	// Observed output by probe index
	function automatic logic [4:0] pick(input int k);
		logic [4:0] s;
		case (k)
			0: s = e0;
			1: s = o0;
			2: s = l0;
			3: s = e1;
			4: s = o1;
			5: s = l1;
			6: s = u0;
			7: s = d0;
			8: s = l2;
			9: s = f2;
			10: s = u2;
			11: s = d2;
			12: s = u1;
			default: s = d1;
		endcase
		return s;
	endfunction
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One APB transfer; bounded wait on pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				fails++;
				tally_and_finish();
			end
			@(posedge clock);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [4:0] d);
		apb(1'b1, a, {27'h0, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic probe(input int k, input logic [4:0] e);
		pq.push_back(e);
		probe_k <= k;
		probe_n <= probe_n + 1;
		@(posedge clock);
	endtask
	// Oldest note against each result as it appears
	always @(posedge clock) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
			check({pslverr, prdata}, rq.pop_front());
		end
		if (probe_n != seen_n && pq.size() > 0) begin
			check({28'h0, pick(probe_k)}, {28'h0, pq.pop_front()});
		end
		seen_n = probe_n;
	end
	// Main sequence
	initial begin
		logic [7:0] b;
		logic [14:0] a;
		logic [4:0] v;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int i = 1; i < 7; i++) begin
			rd(8'(4 * i), 33'h0);
		end
		probe(0, 5'h00);
		probe(3, 5'h00);
		$display("test reset done");
		wr(GPB_OFS_PULL_POL, 5'h0A);
		wr(GPB_OFS_PULL_ON, 5'h1F);
		probe(6, 5'h0A);
		probe(7, 5'h15);
		wr(8'h20 + GPB_OFS_PULL_POL, 5'h11);
		wr(8'h20 + GPB_OFS_PULL_ON, 5'h0F);
		probe(12, 5'h01);
		probe(13, 5'h0E);
		repeat (4) @(posedge clock);
		rd(GPB_OFS_VALUE, 33'h0A);
		probe(2, 5'h0A);
		$display("test pulls done");
		// Both bidirectional ports: output, drain style, every source code
		for (int p = 0; p < 2; p++) begin
			b = 8'(32 * p);
			wr(b + GPB_OFS_WAY, 5'h1F);
			for (int i = 0; i < 4; i++) begin
				r = lfsr(r);
				v = r[4:0];
				wr(b + GPB_OFS_VALUE, v);
				probe(3 * p, 5'h1F);
				probe(3 * p + 1, v);
				rd(b, {28'h0, v});
				wr(b + GPB_OFS_DRAIN, 5'h1F);
				probe(3 * p, ~v);
				wr(b + GPB_OFS_DRAIN, 5'h00);
			end
			for (int c = 0; c < 4; c++) begin
				r = lfsr(r);
				a = {r[6:0], lfsr(r)};
				alt0 <= a;
				alt1 <= a;
				wr(b + GPB_OFS_ALT_LOW, {5{c[0]}});
				wr(b + GPB_OFS_ALT_HIGH, {5{c[1]}});
				probe(3 * p + 1, c == 0 ? v : c == 1 ? a[4:0] : c == 2 ? a[9:5] : a[14:10]);
			end
			probe(3 * p + 2, 5'h00);
		end
		$display("test outputs done");
		wr(8'h40 + GPB_OFS_PULL_POL, 5'h1F);
		wr(8'h40 + GPB_OFS_PULL_ON, 5'h1F);
		wr(8'h40 + GPB_OFS_WAY, 5'h05);
		ana <= r[4:0];
		repeat (4) @(posedge clock);
		probe(10, 5'h1F);
		probe(11, 5'h00);
		probe(8, 5'h05);
		probe(9, r[4:0]);
		rd(8'h40, 33'h05);
		$display("test input port done");
		// Unmapped places answer with an error and read zero
		wr(8'h60, 5'h1F);
		rd(8'h60, 33'h100000000);
		rd(8'h48, 33'h100000000);
		rd(8'h1C, 33'h100000000);
		apb(1'b1, GPB_OFS_DRAIN, 32'hFFFFFFE0);
		rd(GPB_OFS_DRAIN, 33'h0);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		probe(0, 5'h00);
		$display("test refusal and reset done");
		tally_and_finish();
	end
endmodule
